//--- src/period_match_timer8_pkg.sv
// Purpose: constants and carrier types for the 8-bit period timer
// Assumes: byte-wide register port, one 20 MHz clock
// Notes:   offsets are the register-port addresses
package period_match_timer8_pkg;

	// register addresses
	localparam logic [7:0] IRQ_FLAGS_ADDR = 8'h0C;
	localparam logic [7:0] COUNT_ADDR     = 8'h11;
	localparam logic [7:0] CONTROL_ADDR   = 8'h12;
	localparam logic [7:0] IRQ_EN_ADDR    = 8'h8C;
	localparam logic [7:0] PERIOD_ADDR    = 8'h92;

	// values after reset
	localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
	localparam logic [7:0] COUNT_RST     = 8'h00;
	localparam logic [6:0] CONTROL_RST   = 7'h00;
	localparam logic [7:0] IRQ_EN_RST    = 8'h00;
	localparam logic [7:0] PERIOD_RST    = 8'hFF;

	// field positions
	localparam int MATCH_FLAG_BIT = 1;
	localparam int CTL_PRE_LSB    = 0;
	localparam int CTL_RUN_BIT    = 2;
	localparam int CTL_POST_LSB   = 3;

	// instruction clock is the master clock divided by four
	localparam int unsigned MCLK_HZ   = 20_000_000;
	localparam int unsigned INSTR_DIV = 4;
	localparam logic [1:0]  INSTR_LAST = 2'(INSTR_DIV - 1);

	// prescaler terminal counts for 1:1, 1:4, 1:16
	localparam logic [3:0] PRE_LAST_1  = 4'h0;
	localparam logic [3:0] PRE_LAST_4  = 4'h3;
	localparam logic [3:0] PRE_LAST_16 = 4'hF;

	// control register image, bit 7 is not stored
	typedef struct packed {
		logic [3:0] postscale_select;
		logic       timer_run;
		logic [1:0] prescale_select;
	} control_t;

	// time base handed to the capture/compare unit
	typedef struct packed {
		logic [7:0] count;
		logic       match;
	} time_base_t;

endpackage

//--- src/period_match_timer8.sv
// Purpose: 8-bit period-match timer with prescaler and postscaler
// Assumes: software drives the plain register port on mclk_i
// Notes:   read data appear in the cycle after the read strobe only
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module period_match_timer8
	import period_match_timer8_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            irq_req_o,
	output logic            ssp_tick_o,
	output time_base_t      time_base_o
);

	logic [1:0] instr_div_reg;
	logic       instr_tick;
	logic [3:0] pre_cnt_reg;
	logic [3:0] pre_last;
	logic       inc;
	logic [7:0] count_reg;
	logic [7:0] period_reg;
	control_t   control_reg;
	logic       at_period;
	logic       match;
	logic       match_reg;
	logic [3:0] post_cnt_reg;
	logic       post_hit;
	logic       flag_reg;
	logic [7:0] irq_en_reg;
	logic       count_wr;
	logic       control_wr;
	logic [7:0] rdata_next;

	// write decode
	assign count_wr   = wr_i && (addr_i == COUNT_ADDR);
	assign control_wr = wr_i && (addr_i == CONTROL_ADDR);

	// instruction clock enable, free running
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			instr_div_reg <= 2'h0;
		else if (instr_tick)
			instr_div_reg <= 2'h0;
		else
			instr_div_reg <= instr_div_reg + 2'h1;
	end

	assign instr_tick = (instr_div_reg == INSTR_LAST);

	// prescale ratio decode
	always_comb
	begin
		unique case (control_reg.prescale_select)
			2'b00:   pre_last = PRE_LAST_1;
			2'b01:   pre_last = PRE_LAST_4;
			2'b10:   pre_last = PRE_LAST_16;
			2'b11:   pre_last = PRE_LAST_16;
		endcase
	end

	// timer increment enable
	assign inc = instr_tick && control_reg.timer_run
		&& (pre_cnt_reg == pre_last);

	// prescaler counter
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			pre_cnt_reg <= 4'h0;
		else if (count_wr || control_wr)
			pre_cnt_reg <= 4'h0;
		else if (inc)
			pre_cnt_reg <= 4'h0;
		else if (instr_tick && control_reg.timer_run)
			pre_cnt_reg <= pre_cnt_reg + 4'h1;
	end

	// period compare
	assign at_period = (count_reg == period_reg);
	assign match     = inc && at_period;

	// timer count, software write wins over an increment
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			count_reg <= COUNT_RST;
		else if (count_wr)
			count_reg <= wdata_i;
		else if (match)
			count_reg <= 8'h00;
		else if (inc)
			count_reg <= count_reg + 8'h01;
	end

	// period register
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			period_reg <= PERIOD_RST;
		else if (wr_i && addr_i == PERIOD_ADDR)
			period_reg <= wdata_i;
	end

	// control register, count is not touched here
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			control_reg <= CONTROL_RST;
		else if (control_wr)
			control_reg <= wdata_i[6:0];
	end

	// postscaler counter
	assign post_hit = match
		&& (post_cnt_reg == control_reg.postscale_select);

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			post_cnt_reg <= 4'h0;
		else if (count_wr || control_wr)
			post_cnt_reg <= 4'h0;
		else if (post_hit)
			post_cnt_reg <= 4'h0;
		else if (match)
			post_cnt_reg <= post_cnt_reg + 4'h1;
	end

	// match flag, a new hit beats a software clear
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			flag_reg <= IRQ_FLAGS_RST[MATCH_FLAG_BIT];
		else if (post_hit)
			flag_reg <= 1'b1;
		else if (wr_i && addr_i == IRQ_FLAGS_ADDR)
			flag_reg <= wdata_i[MATCH_FLAG_BIT];
	end

	// interrupt enables
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_en_reg <= IRQ_EN_RST;
		else if (wr_i && addr_i == IRQ_EN_ADDR)
			irq_en_reg <= wdata_i;
	end

	// gated interrupt request
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_req_o <= 1'b0;
		else
			irq_req_o <= flag_reg && irq_en_reg[MATCH_FLAG_BIT];
	end

	// match pulse for serial port and PWM time base
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			match_reg <= 1'b0;
		else
			match_reg <= match;
	end

	assign ssp_tick_o        = match_reg;
	assign time_base_o       = {count_reg, match_reg};

	// read mux
	always_comb
	begin
		rdata_next = 8'h00;
		if (rd_i)
		begin
			unique case (addr_i)
				IRQ_FLAGS_ADDR:
					rdata_next[MATCH_FLAG_BIT] = flag_reg;
				COUNT_ADDR:   rdata_next = count_reg;
				CONTROL_ADDR: rdata_next = {1'b0, control_reg};
				IRQ_EN_ADDR:  rdata_next = irq_en_reg;
				PERIOD_ADDR:  rdata_next = period_reg;
				default:      rdata_next = 8'h00;
			endcase
		end
	end

	// read data register, valid one cycle after the strobe
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= rdata_next;
	end

	// instruction enable: one pulse then three quiet cycles
	sequence s_instr_gap;
		!instr_tick [*3] ##1 instr_tick;
	endsequence

	property p_instr_div;
		@(posedge mclk_i) disable iff (rst_i)
		instr_tick |=> s_instr_gap;
	endproperty
	a_instr_div: assert property (p_instr_div)
		else $error("instruction enable not every fourth cycle");

	property p_wrap;
		@(posedge mclk_i) disable iff (rst_i)
		inc && at_period && !count_wr |=> count_reg == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("count did not return to zero at period");

	property p_step;
		@(posedge mclk_i) disable iff (rst_i)
		inc && !at_period && !count_wr
		|=> count_reg == $past(count_reg) + 8'h01;
	endproperty
	a_step: assert property (p_step)
		else $error("count did not step by one");

	property p_period_reset;
		@(posedge mclk_i)
		$fell(rst_i) |-> period_reg == 8'hFF;
	endproperty
	a_period_reset: assert property (p_period_reset)
		else $error("period not all ones after reset");

	property p_div1;
		@(posedge mclk_i) disable iff (rst_i)
		instr_tick && control_reg.timer_run
		&& control_reg.prescale_select == 2'b00 |-> inc;
	endproperty
	a_div1: assert property (p_div1)
		else $error("1:1 prescale missed an increment");

	// sixteen-way prescale: no increment in the next 8 cycles while 1:16 stays selected
	sequence s_pre16_hold;
		(!inc || !control_reg.prescale_select[1]) [*8];
	endsequence

	property p_div16;
		@(posedge mclk_i) disable iff (rst_i)
		inc && control_reg.prescale_select[1] && !control_wr
		|=> s_pre16_hold;
	endproperty
	a_div16: assert property (p_div16)
		else $error("1:16 prescale incremented too soon");

	property p_post;
		@(posedge mclk_i) disable iff (rst_i)
		post_hit |=> flag_reg
			##1 irq_req_o == $past(irq_en_reg[MATCH_FLAG_BIT]);
	endproperty
	a_post: assert property (p_post)
		else $error("postscaled match did not raise the flag");

	property p_clear;
		@(posedge mclk_i) disable iff (rst_i)
		count_wr || control_wr
		|=> pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("scalers not cleared by a write");

	property p_ctl_keeps;
		@(posedge mclk_i) disable iff (rst_i)
		control_wr && !count_wr && !inc |=> $stable(count_reg);
	endproperty
	a_ctl_keeps: assert property (p_ctl_keeps)
		else $error("control write disturbed the count");

	property p_stopped;
		@(posedge mclk_i) disable iff (rst_i)
		!control_reg.timer_run && !count_wr && !control_wr
		|=> $stable(count_reg) && $stable(post_cnt_reg);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("stopped timer moved");

	property p_bit7;
		@(posedge mclk_i) disable iff (rst_i)
		rd_i && addr_i == CONTROL_ADDR |=> rdata_o[7] == 1'b0;
	endproperty
	a_bit7: assert property (p_bit7)
		else $error("control bit 7 read as one");

	property p_ssp;
		@(posedge mclk_i) disable iff (rst_i)
		match && !count_wr |=> ssp_tick_o && time_base_o.count == 8'h00;
	endproperty
	a_ssp: assert property (p_ssp)
		else $error("match pulse or time base wrong");

	property p_flag_holds;
		@(posedge mclk_i) disable iff (rst_i)
		flag_reg && !(wr_i && addr_i == IRQ_FLAGS_ADDR)
		|=> flag_reg;
	endproperty
	a_flag_holds: assert property (p_flag_holds)
		else $error("match flag dropped without software");

endmodule

`default_nettype wire

//--- tb/period_match_timer8_tb_top.sv
// Purpose: self-checking bench for the 8-bit period timer
// Assumes: register port driven at the rising edge, seed fixed
// Notes:   expected gaps and ratios come from bench functions
`timescale 1ns/10ps
`default_nettype none
module period_match_timer8_tb_top
	import period_match_timer8_pkg::*;
;
	logic       mclk_i;
	logic       rst_i;
	logic [7:0] addr_i;
	logic [7:0] wdata_i;
	logic       wr_i;
	logic       rd_i;
	logic [7:0] rdata_o;
	logic       irq_req_o;
	logic       ssp_tick_o;
	time_base_t time_base_o;
	logic [7:0] v;
	logic [7:0] p;
	logic [7:0] post;
	int         n;
	int         k;
	int         fail_count;
	int         cmp_count;

	period_match_timer8 u_period_match_timer8 (
		.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .irq_req_o(irq_req_o),
		.ssp_tick_o(ssp_tick_o), .time_base_o(time_base_o));

	// 20 MHz clock
	always #25 mclk_i = ~mclk_i;

	// prescale divide ratio from its select code
	function automatic int pre_div(input int code);
		return (code == 0) ? 1 : (code == 1) ? 4 : 16;
	endfunction

	// master clocks between two period matches
	function automatic int tick_gap(input logic [7:0] per, input int code);
		return (int'(per) + 1) * INSTR_DIV * pre_div(code);
	endfunction

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one-cycle write strobe
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i    <= 1'b0;
		wdata_i <= ~d;
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i   <= 1'b0;
		#1 v = rdata_o;
		check(what, 16'(v), 16'(exp));
	endtask

	// cycles until the next match pulse, bounded
	task automatic wait_tick(output int cnt);
		cnt = 0;
		do
		begin
			@(posedge mclk_i);
			#1 cnt++;
		end
		while (ssp_tick_o !== 1'b1 && cnt < 4000);
	endtask

	// hang guard
	initial
	begin
		repeat (40000) @(posedge mclk_i);
		fail_count++;
		give_verdict();
	end

	initial
	begin
		mclk_i = 1'b0;
		rst_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		void'($urandom(13));
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		// reset values and register access
		rd_chk(PERIOD_ADDR, 8'hFF, "period rst");
		rd_chk(COUNT_ADDR, 8'h00, "count rst");
		rd_chk(CONTROL_ADDR, 8'h00, "control rst");
		rd_chk(IRQ_FLAGS_ADDR, 8'h00, "flags rst");
		rd_chk(IRQ_EN_ADDR, 8'h00, "enables rst");
		rd_chk(8'h13, 8'h00, "unmapped");
		p = 8'($urandom);
		reg_wr(PERIOD_ADDR, p);
		rd_chk(PERIOD_ADDR, p, "period rw");
		reg_wr(CONTROL_ADDR, 8'hF8);
		rd_chk(CONTROL_ADDR, 8'h78, "control bit7");
		p = 8'($urandom);
		reg_wr(COUNT_ADDR, p);
		rd_chk(COUNT_ADDR, p, "count rw");
		reg_wr(CONTROL_ADDR, 8'h02);
		repeat (100) @(posedge mclk_i);
		rd_chk(COUNT_ADDR, p, "count kept");
		// prescaler cleared by a count write, first step after 61..64
		reg_wr(PERIOD_ADDR, 8'hFF);
		reg_wr(CONTROL_ADDR, 8'h06);
		repeat (30) @(posedge mclk_i);
		reg_wr(COUNT_ADDR, 8'h00);
		n = 0;
		do
		begin
			@(posedge mclk_i);
			#1 n++;
		end
		while (time_base_o.count !== 8'h01 && n < 200);
		k = tick_gap(8'h00, 2) / INSTR_DIV - 1;
		check("pre clear", 16'((n - 1) / INSTR_DIV), 16'(k));
		// match spacing for every prescale code
		for (k = 0; k < 4; k++)
		begin
			p = 8'($urandom_range(7));
			reg_wr(PERIOD_ADDR, p);
			reg_wr(CONTROL_ADDR, 8'(k) | 8'h04);
			reg_wr(COUNT_ADDR, 8'h00);
			wait_tick(n);
			check("wrap", 16'(time_base_o.count), 16'h0);
			check("pwm match", 16'(time_base_o.match), 16'h1);
			wait_tick(n);
			check("gap", 16'(n), 16'(tick_gap(p, k)));
		end
		// postscaler ratio, corners then random
		reg_wr(PERIOD_ADDR, 8'h01);
		reg_wr(IRQ_EN_ADDR, 8'h02);
		for (k = 0; k < 5; k++)
		begin
			post = (k == 0) ? 8'h0 : (k == 1) ? 8'hF : 8'($urandom_range(14));
			reg_wr(CONTROL_ADDR, 8'h00);
			reg_wr(IRQ_FLAGS_ADDR, 8'h00);
			reg_wr(COUNT_ADDR, 8'h00);
			reg_wr(CONTROL_ADDR, {1'b0, post[3:0], 3'b100});
			n = 0;
			v = 8'h00;
			while (irq_req_o !== 1'b1 && v < 8'hFF)
			begin
				@(posedge mclk_i);
				#1 v++;
				if (ssp_tick_o === 1'b1)
					n++;
			end
			check("post ratio", 16'(n), 16'(post) + 16'h1);
		end
		// stopped timer holds a written count, flag stays, enable gates
		reg_wr(CONTROL_ADDR, 8'h00);
		p = 8'($urandom);
		reg_wr(COUNT_ADDR, p);
		repeat (64) @(posedge mclk_i);
		#1 check("hold", 16'(time_base_o.count), 16'(p));
		rd_chk(COUNT_ADDR, p, "hold2");
		rd_chk(IRQ_FLAGS_ADDR, 8'h02, "flag set");
		reg_wr(IRQ_EN_ADDR, 8'h00);
		repeat (2) @(posedge mclk_i);
		#1 check("masked", 16'(irq_req_o), 16'h0);
		reg_wr(IRQ_EN_ADDR, 8'h02);
		repeat (2) @(posedge mclk_i);
		#1 check("unmasked", 16'(irq_req_o), 16'h1);
		reg_wr(IRQ_FLAGS_ADDR, 8'h00);
		rd_chk(IRQ_FLAGS_ADDR, 8'h00, "flag clr");
		// reset in mid-run while the timer counts on from the held count
		reg_wr(PERIOD_ADDR, 8'h03);
		reg_wr(CONTROL_ADDR, 8'h04);
		repeat (40) @(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd_chk(PERIOD_ADDR, PERIOD_RST, "period rst2");
		rd_chk(COUNT_ADDR, COUNT_RST, "count rst2");
		rd_chk(CONTROL_ADDR, 8'h00, "control rst2");
		rd_chk(IRQ_FLAGS_ADDR, IRQ_FLAGS_RST, "flags rst2");
		give_verdict();
	end
endmodule
`default_nettype wire
